// ===== verilog/swc_ctrl.sv
// Stop mode entry, wake sources, wake timer and supply monitor control.
//
// Chosen here: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
// Operation
// - In ordinary stop, hold CPU halted while keeping CPU state and memory.
// - Ordinary stop exits on external irq, warning, bus command, fail reset.
// - Software enters stop whenever it likes by writing the stop bit.
// - Retention with regulator off keeps only words 0000h to 00FFh.
// - Retention powers down CPU status and shared bus/cipher memory.
// - Leaving retention stop always goes through a full power-on reset.
// - Retention exits on ext irq, ext reset, warning, bus command, timer.
// - Wake timer ends stop after a software-chosen period.
// - Monitor always on when running; on in stop unless disabled.
// - Monitor-disable set in stop shuts off warning and fail detection.
// - A drop below the power-on level still gives power-on reset.
// - Monitor re-enabled before exit; warning flags, fail holds reset.
// - Bus wake: reset pulse powers controller; addressed wakes, else sleep.
// - Overdrive-speed reset pulses are ignored during stop.
module swc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire swc_pkg::swc_wb_req_t wb_req_i,
  input wire swc_pkg::swc_pwr_in_t pwr_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic cpu_halt_o,
  output logic cpu_reset_o,
  output logic por_o,
  output logic monitor_en_o,
  output logic bus_ctrl_pwr_o,
  output logic retained_only_o,
  output logic shared_mem_pwr_o
);
  import swc_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  swc_state_t state_reg;
  logic [31:0] ctrl_reg;
  logic [31:0] wtmr_reg;
  logic [31:0] tcnt_reg;
  logic [SWC_F_BITS-1:0] iflg_reg;
  logic [SWC_F_BITS-1:0] imsk_reg;
  logic ret_reg;
  logic wake_ext_reg;

  wire wb_hit = wb_req_i.cyc & wb_req_i.stb & ~wb_ack_o;
  wire wb_wr = wb_hit & wb_req_i.we & wb_req_i.sel[0];
  wire in_stop = (state_reg == SWC_STOP) | (state_reg == SWC_PROBE) |
                 (state_reg == SWC_CHECK);
  wire ret_mode = ctrl_reg[SWC_C_RET] & ~ctrl_reg[SWC_C_REGON];
  // Monitor runs whenever awake, and in stop unless software turned it off.
  wire mon_live = ~in_stop | ~ctrl_reg[SWC_C_MOFF];
  wire warn_ev = mon_live & pwr_i.below_warning;
  wire fail_ev = mon_live & pwr_i.below_reset;
  wire tmr_ev = in_stop & ctrl_reg[SWC_C_TMREN] &
                (tcnt_reg == wtmr_reg);
  wire bus_ev = (state_reg == SWC_CHECK) & pwr_i.bus_addressed;
  // Wake events and the enabled ones; flags record every event, masked or not, as a sticky interrupt cause.
  wire [SWC_F_BITS-1:0] ev = {tmr_ev, bus_ev, warn_ev, pwr_i.ext_irq};
  wire wake_src = |(ev & (imsk_reg | 4'h4)) | fail_ev;

  // Byte write merge used by the control and wake period registers.
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------------
  // Bus slave: one wait-free ack per request, dropped the cycle after.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= SWC_UNMAPPED;
    end else begin
      wb_ack_o <= wb_hit;
      case (wb_req_i.adr)
        SWC_ADDR_CTRL: wb_dat_o <= ctrl_reg;
        SWC_ADDR_STAT: wb_dat_o <= {28'h0, ret_reg, mon_live, in_stop,
                                    cpu_reset_o};
        SWC_ADDR_IFLG: wb_dat_o <= {28'h0, iflg_reg};
        SWC_ADDR_IMSK: wb_dat_o <= {28'h0, imsk_reg};
        SWC_ADDR_WTMR: wb_dat_o <= wtmr_reg;
        default: wb_dat_o <= SWC_UNMAPPED;
      endcase
    end
  end

  // Control register; the stop bit self-clears once stop is entered.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= SWC_CTRL_RST;
    end else if (wb_hit && wb_req_i.we &&
                 wb_req_i.adr == SWC_ADDR_CTRL) begin
      ctrl_reg <= wmerge(ctrl_reg, wb_req_i.dat, wb_req_i.sel);
    end else if (state_reg == SWC_STOP) begin
      ctrl_reg[SWC_C_STOP] <= 1'b0;
    end else if (por_o) begin
      ctrl_reg <= SWC_CTRL_RST; // Retention loses the control register; the mask and wake period registers stay.
    end
  end

  // Wake period and mask registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wtmr_reg <= SWC_WTMR_RST;
      imsk_reg <= '0;
    end else if (wb_hit && wb_req_i.we) begin
      if (wb_req_i.adr == SWC_ADDR_WTMR) begin
        wtmr_reg <= wmerge(wtmr_reg, wb_req_i.dat, wb_req_i.sel);
      end
      if (wb_req_i.adr == SWC_ADDR_IMSK && wb_req_i.sel[0]) begin
        imsk_reg <= wb_req_i.dat[SWC_F_BITS-1:0];
      end
    end
  end

  // Sticky flags: write one to clear, a new event in the same cycle wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iflg_reg <= '0;
    end else begin
      if (wb_wr && wb_req_i.adr == SWC_ADDR_IFLG) begin
        iflg_reg <= (iflg_reg & ~wb_req_i.dat[SWC_F_BITS-1:0]) | ev;
      end else begin
        iflg_reg <= iflg_reg | ev;
      end
    end
  end

  // Wake timer counts only in stop with the timer enabled.
  always_ff @(posedge clk_i) begin
    if (rst_i || !in_stop || !ctrl_reg[SWC_C_TMREN]) begin
      tcnt_reg <= '0;
    end else if (!tmr_ev) begin
      tcnt_reg <= tcnt_reg + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= SWC_RUN;
      ret_reg <= 1'b0;
      wake_ext_reg <= 1'b0;
    end else begin
      wake_ext_reg <= 1'b0;
      case (state_reg)
        SWC_RUN: begin
          if (ctrl_reg[SWC_C_STOP]) begin
            state_reg <= SWC_STOP;
            ret_reg <= ret_mode;
          end else if (wake_ext_reg) begin
            // Held one cycle past wake so the retention reset still sees it.
            ret_reg <= 1'b0;
          end
        end
        SWC_STOP: begin
          if (wake_src) begin
            state_reg <= SWC_WAKE;
          end else if (ctrl_reg[SWC_C_BUSWK] && pwr_i.bus_std_reset) begin
            state_reg <= SWC_PROBE; // overdrive is not seen
          end
        end
        SWC_PROBE: begin
          state_reg <= wake_src ? SWC_WAKE : SWC_CHECK;
        end
        SWC_CHECK: begin
          if (wake_src) begin
            state_reg <= SWC_WAKE;
          end else if (pwr_i.bus_not_addressed) begin
            state_reg <= SWC_STOP;
          end
        end
        SWC_WAKE: begin
          // Monitor is live here, before the CPU is released.
          state_reg <= SWC_RUN;
          wake_ext_reg <= 1'b1;
        end
        default: state_reg <= SWC_RUN;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Power outputs, all registered.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cpu_halt_o <= 1'b0;
      cpu_reset_o <= 1'b0;
      por_o <= 1'b0;
      monitor_en_o <= 1'b1;
      bus_ctrl_pwr_o <= 1'b1;
      retained_only_o <= 1'b0;
      shared_mem_pwr_o <= 1'b1;
      irq_o <= 1'b0;
    end else begin
      cpu_halt_o <= in_stop | (state_reg == SWC_WAKE);
      // Fail holds the CPU in reset; a POR drop acts even when unmonitored.
      cpu_reset_o <= fail_ev | pwr_i.below_por;
      por_o <= pwr_i.below_por | (wake_ext_reg & ret_reg);
      monitor_en_o <= mon_live | (state_reg == SWC_WAKE);
      bus_ctrl_pwr_o <= ~in_stop | (state_reg == SWC_PROBE) |
                        (state_reg == SWC_CHECK);
      retained_only_o <= in_stop & ret_reg;
      shared_mem_pwr_o <= ~(in_stop & ret_reg);
      irq_o <= |(iflg_reg & imsk_reg);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_HALT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP) |=> cpu_halt_o)
    else $error("CPU not halted in stop.");
  AST_ENTER: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_RUN && ctrl_reg[SWC_C_STOP]) |=>
      state_reg == SWC_STOP)
    else $error("Stop not entered.");
  AST_RETMEM: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_stop && ret_reg) |=> !shared_mem_pwr_o && retained_only_o)
    else $error("Shared memory powered in retention.");
  AST_RETPOR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_WAKE && ret_reg) |=> ##1 por_o)
    else $error("No reset after retention exit.");
  AST_NOPOR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_WAKE && !ret_reg && !pwr_i.below_por) |=>
      ##1 !por_o || $past(pwr_i.below_por))
    else $error("Reset on plain stop exit.");
  AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP && pwr_i.ext_irq && imsk_reg[SWC_F_EXT]) |=>
      state_reg == SWC_WAKE ##1 state_reg == SWC_RUN)
    else $error("External interrupt did not wake.");
  AST_MOFF: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP && ctrl_reg[SWC_C_MOFF]) |=>
      !monitor_en_o && (!cpu_reset_o || $past(pwr_i.below_por)))
    else $error("Monitor live with disable set.");
  AST_POR: assert property (@(posedge clk_i) disable iff (rst_i)
    pwr_i.below_por |=> por_o && cpu_reset_o)
    else $error("Power-on reset missed.");
  AST_OD: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP && !pwr_i.bus_std_reset && !wake_src) |=>
      state_reg == SWC_STOP)
    else $error("Stop left without cause.");
  AST_PROBE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_CHECK && pwr_i.bus_not_addressed && !wake_src) |=>
      state_reg == SWC_STOP ##1 !bus_ctrl_pwr_o)
    else $error("Bus controller not powered down.");
  AST_ODIGN: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP && pwr_i.bus_od_reset &&
     !pwr_i.bus_std_reset && !wake_src) |=> state_reg == SWC_STOP)
    else $error("Overdrive reset pulse acted in stop.");
  AST_TMR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_STOP && tmr_ev && imsk_reg[SWC_F_TMR]) |=>
      state_reg == SWC_WAKE)
    else $error("Wake timer expiry did not wake.");
  AST_TMRCNT: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_stop && ctrl_reg[SWC_C_TMREN] && !tmr_ev) |=>
      tcnt_reg == $past(tcnt_reg) + 32'h1)
    else $error("Wake timer did not advance.");
  AST_MONRUN: assert property (@(posedge clk_i) disable iff (rst_i)
    !in_stop |=> monitor_en_o)
    else $error("Monitor off while running.");
  AST_FAIL: assert property (@(posedge clk_i) disable iff (rst_i)
    (!in_stop && pwr_i.below_reset) |=> cpu_reset_o)
    else $error("Supply fail did not hold the CPU in reset.");
  AST_WARNFLG: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_WAKE && pwr_i.below_warning) |=>
      iflg_reg[SWC_F_WARN])
    else $error("Warning on wake not flagged.");
  AST_MONWAKE: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_WAKE) |=> monitor_en_o)
    else $error("Monitor not live before release.");
  AST_BUSPWR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_PROBE) |=> bus_ctrl_pwr_o)
    else $error("Bus controller not powered for probe.");
  AST_BUSHIT: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_CHECK && pwr_i.bus_addressed) |=>
      state_reg == SWC_WAKE)
    else $error("Addressed device did not wake.");
  AST_PLAINMEM: assert property (@(posedge clk_i) disable iff (rst_i)
    (in_stop && !ret_reg) |=> shared_mem_pwr_o && !retained_only_o)
    else $error("Memory dropped in plain stop.");
  AST_RETSEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == SWC_RUN && ctrl_reg[SWC_C_STOP]) |=>
      ret_reg == $past(ctrl_reg[SWC_C_RET] && !ctrl_reg[SWC_C_REGON]))
    else $error("Retention choice not captured on entry.");
endmodule // swc_ctrl

// ===== verilog/swc_pkg.sv
// Package of constants and types for the stop mode wake controller.
package swc_pkg;
  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SWC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SWC_ADDR_STAT = 8'h04;
  localparam logic [7:0] SWC_ADDR_IFLG = 8'h08;
  localparam logic [7:0] SWC_ADDR_IMSK = 8'h0c;
  localparam logic [7:0] SWC_ADDR_WTMR = 8'h10;
  // ----------------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------------
  localparam int SWC_C_STOP = 0;
  localparam int SWC_C_RET = 1;
  localparam int SWC_C_REGON = 2;
  localparam int SWC_C_MOFF = 3;
  localparam int SWC_C_BUSWK = 4;
  localparam int SWC_C_TMREN = 5;
  localparam logic [31:0] SWC_CTRL_RST = 32'h0000_0004;
  localparam logic [31:0] SWC_CTRL_MASK = 32'h0000_003e;
  // ----------------------------------------------------------------------
  // Interrupt flag bits
  // ----------------------------------------------------------------------
  localparam int SWC_F_EXT = 0;
  localparam int SWC_F_WARN = 1;
  localparam int SWC_F_BUS = 2;
  localparam int SWC_F_TMR = 3;
  localparam int SWC_F_BITS = 4;
  localparam logic [31:0] SWC_WTMR_RST = 32'h0000_ffff;
  localparam int SWC_RET_LAST_WORD = 16'h00ff;
  localparam logic [31:0] SWC_UNMAPPED = 32'h0000_0000;

  typedef enum {SWC_RUN, SWC_STOP, SWC_PROBE, SWC_CHECK, SWC_WAKE}
    swc_state_t;

  // Wishbone request carried as one bundle.
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } swc_wb_req_t;

  // Power and wake inputs from the analogue and bus front ends.
  typedef struct packed {
    logic ext_irq;
    logic below_warning;
    logic below_reset;
    logic below_por;
    logic bus_std_reset;
    logic bus_od_reset;
    logic bus_addressed;
    logic bus_not_addressed;
  } swc_pwr_in_t;
endpackage

// ===== tb/swc_bus_master.sv
// Behavioural single-wire bus master driving the wake front-end levels.
`timescale 1ns/10ps
module swc_bus_master (
  input wire logic clk_i,
  output logic std_rst_o,
  output logic od_rst_o,
  output logic addr_o,
  output logic naddr_o
);
  initial begin
    {std_rst_o, od_rst_o, addr_o, naddr_o} = 4'h0;
  end
  // One reset pulse of one clock; overdrive or standard speed.
  task automatic rst_pulse(input logic od);
    @(posedge clk_i);
    std_rst_o <= !od;
    od_rst_o <= od;
    @(posedge clk_i);
    {std_rst_o, od_rst_o} <= 2'h0;
  endtask
  // Presence answer; the line is released after two cycles.
  task automatic answer(input logic hit);
    @(posedge clk_i);
    addr_o <= hit;
    naddr_o <= !hit;
    repeat (2) @(posedge clk_i);
    {addr_o, naddr_o} <= 2'h0;
  endtask
endmodule // swc_bus_master

// ===== tb/swc_ctrl_tb.sv
// Self-checking bench for the stop mode wake controller.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin \
  n_fail++; $display("Error %s exp %h got %h", nm, e, a); end end
module swc_ctrl_tb;
  import swc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  swc_wb_req_t req = '0;
  swc_pwr_in_t pwr;
  logic ext = 1'b0, warn = 1'b0, frst = 1'b0, por = 1'b0;
  logic sr, od, ad, na, ack, irq, halt, crst, poro, mon, bpw, ret, shm;
  logic [31:0] dat, q;
  int n_fail = 0, comparisons = 0;
  assign pwr = '{ext, warn, frst, por, sr, od, ad, na};
  // Clock of 25 ns period.
  always #12.5 clk = ~clk;
  swc_ctrl i_swc_ctrl (.clk_i(clk), .rst_i(rst), .wb_req_i(req),
    .pwr_i(pwr), .wb_dat_o(dat), .wb_ack_o(ack), .irq_o(irq),
    .cpu_halt_o(halt), .cpu_reset_o(crst), .por_o(poro),
    .monitor_en_o(mon), .bus_ctrl_pwr_o(bpw), .retained_only_o(ret),
    .shared_mem_pwr_o(shm));
  swc_bus_master i_swc_bus_master (.clk_i(clk), .std_rst_o(sr),
    .od_rst_o(od), .addr_o(ad), .naddr_o(na));
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Classic single cycle; waits for ack under a bound.
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{1'b1, 1'b1, we, 4'hf, a, d};
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin n_fail++; finish_test(); end
    end while (ack !== 1'b1);
    q = dat;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (halt !== v) begin
      @(posedge clk);
      n++;
      if (n > 300) begin n_fail++; finish_test(); end
    end
    @(posedge clk);
  endtask
  task automatic t_reset();
    `CHK("mon", 1'b1, mon)
    `CHK("shm", 1'b1, shm)
    wb(0, SWC_ADDR_CTRL, 0); `CHK("ctrl", SWC_CTRL_RST, q)
    wb(0, SWC_ADDR_WTMR, 0); `CHK("wtmr", SWC_WTMR_RST, q)
    wb(1, 8'h3c, 32'hffff); wb(0, 8'h3c, 0); `CHK("unmap", 32'h0, q)
    $display("t_reset done");
  endtask
  task automatic t_stop_ext();
    wb(1, SWC_ADDR_IMSK, 32'h1);
    wb(1, SWC_ADDR_CTRL, 32'h5); wait_halt(1);
    `CHK("halt", 1'b1, halt)
    `CHK("ret", 1'b0, ret)
    ext <= 1'b1; wait_halt(0); ext <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("por", 1'b0, poro)
    `CHK("irq", 1'b1, irq)
    wb(1, SWC_ADDR_IFLG, 32'h1); repeat (2) @(posedge clk);
    `CHK("irqclr", 1'b0, irq)
    $display("t_stop_ext done");
  endtask
  task automatic t_mon_off();
    wb(1, SWC_ADDR_CTRL, 32'hd); wait_halt(1);
    `CHK("mon", 1'b0, mon)
    frst <= 1'b1; repeat (5) @(posedge clk);
    `CHK("crst", 1'b0, crst)
    `CHK("halt", 1'b1, halt)
    frst <= 1'b0; warn <= 1'b1; ext <= 1'b1; wait_halt(0);
    ext <= 1'b0; warn <= 1'b0;
    `CHK("mon", 1'b1, mon)
    wb(0, SWC_ADDR_IFLG, 0); `CHK("wflg", 1'b1, q[SWC_F_WARN])
    wb(1, SWC_ADDR_IFLG, 32'hf);
    por <= 1'b1; repeat (3) @(posedge clk);
    `CHK("por", 1'b1, poro)
    por <= 1'b0; repeat (5) @(posedge clk);
    frst <= 1'b1; repeat (2) @(posedge clk);
    `CHK("crun", 1'b1, crst)
    frst <= 1'b0;
    $display("t_mon_off done");
  endtask
  task automatic t_retain();
    int n;
    logic seen;
    seen = 1'b0;
    wb(1, SWC_ADDR_WTMR, 32'd20); wb(1, SWC_ADDR_IMSK, 32'h8);
    wb(1, SWC_ADDR_CTRL, 32'h23); wait_halt(1);
    `CHK("ret", 1'b1, ret)
    `CHK("shm", 1'b0, shm)
    // The reset after retention lasts one cycle, so look at every edge.
    for (n = 0; n < 100 && !seen; n++) begin
      @(posedge clk);
      if (poro === 1'b1) seen = 1'b1;
    end
    `CHK("porx", 1'b1, seen)
    `CHK("wake", 1'b0, halt)
    wb(0, SWC_ADDR_CTRL, 0); `CHK("ctrl", SWC_CTRL_RST, q)
    $display("t_retain done");
  endtask
  task automatic t_bus();
    wb(1, SWC_ADDR_IMSK, 32'h0);
    wb(1, SWC_ADDR_CTRL, 32'h15); wait_halt(1);
    i_swc_bus_master.rst_pulse(1); repeat (4) @(posedge clk);
    `CHK("od", 1'b1, halt)
    i_swc_bus_master.rst_pulse(0); repeat (2) @(posedge clk);
    `CHK("bpw", 1'b1, bpw)
    i_swc_bus_master.answer(0); repeat (4) @(posedge clk);
    `CHK("nhit", 1'b1, halt)
    `CHK("bpwoff", 1'b0, bpw)
    i_swc_bus_master.rst_pulse(0); i_swc_bus_master.answer(1);
    wait_halt(0); `CHK("hit", 1'b0, halt)
    $display("t_bus done");
  endtask
  // Main sequence; a ten cycle reset, then each scenario.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_stop_ext();
    t_mon_off();
    t_retain();
    t_bus();
    finish_test();
  end
endmodule // swc_ctrl_tb
